// ==== rtl/adcc_control.v ====
// converter control: registers, pin takeover, sequencing and result formatting
//
// Notes on behaviour
// - selected channel pin is forced to analog input, off port logic
// - unselected pins stay ordinary port I/O
// - port output and direction writes do not affect the selected pin
// - reading the selected pin's port bit returns zero
// - result is 3FF at upper reference, 000 at lower, linear between
// - conversion starts on control write, ends 18 conversion clocks later, 17 per continuous repeat
// - continuous mode overwrites results and runs until continuous bit cleared
// - without interrupt enable, done flag set per conversion until result read
// - single mode does one conversion per control write
// - four result formats chosen by two-bit mode in clock register
// - left mode: 8 high bits high, 2 low bits low; read low after high
// - right mode: top 2 bits high, low 8 bits low
// - signed left mode inverts top result bit
// - truncation: top 8 bits in low register, no interlock
// - interrupt enable raises interrupt per conversion, done flag unused
// - converter runs in wait mode; interrupt can wake processor
// - stop aborts conversion; after stop first cycle only stabilises
// - five-bit channel field: 0-7 pins, refs high codes, all ones off
// - with interrupt enable, done flag never set, reads zero
// - interrupt cleared on result read or control write
// - high read freezes low until read; results in between dropped
`timescale 1ns/1ps
`include "adcc_defines.vh"
module adcc_control #(
  parameter NPINS = 8,
  parameter RES_W = 10
) (
  input wire mclk,
  input wire reset,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire osc_clk_en,
  input wire stop_mode,
  input wire [NPINS-1:0] port_pin_in,
  output reg [NPINS-1:0] port_pin_out,
  output reg [NPINS-1:0] port_pin_oe,
  output reg [4:0] channel_select,
  output reg sample_hold,
  output reg [RES_W-1:0] sar_trial,
  input wire sar_compare_hi,
  output reg converter_power_on,
  output reg conv_irq
);
  localparam ST_IDLE = 2'h0;
  localparam ST_STAB = 2'h1;
  localparam ST_CONV = 2'h2;
  reg [1:0] state_q;
  reg cont_q;
  reg ien_q;
  reg done_q;
  reg ack_q;
  reg stopped_q;
  reg [7:0] clkcfg_q;
  reg [NPINS-1:0] pout_q;
  reg [NPINS-1:0] pdir_q;
  reg [RES_W-1:0] sar_q;
  reg [4:0] step_q;
  reg [4:0] div_q;
  reg [7:0] rh_q;
  reg [7:0] rl_q;
  reg frozen_q;
  reg [4:0] divmax;
  wire [1:0] jmode = clkcfg_q[`ADCC_CLK_MODE_HI:`ADCC_CLK_MODE_LO];
  wire acc = (avs_read | avs_write) & ~ack_q;
  wire wr = avs_write & acc;
  wire rd = avs_read & acc;
  wire scr_wr = wr & (avs_address == `ADCC_OFF_SCR) & avs_byteenable[0];
  wire rh_rd = rd & (avs_address == `ADCC_OFF_RH);
  wire rl_rd = rd & (avs_address == `ADCC_OFF_RL);
  wire pwr_off = (channel_select == `ADCC_CH_OFF);
  wire src_en = clkcfg_q[`ADCC_CLK_SRC] | osc_clk_en;
  wire ctick = src_en & (div_q == divmax);
  wire last_step = (step_q == `ADCC_CONV_CYCLES - 5'h1);
  wire [RES_W-1:0] bitmask = {{(RES_W-1){1'b0}}, 1'b1} << (5'd9 - step_q[3:0]);
  wire [RES_W-1:0] final_res = sar_compare_hi ? sar_q : (sar_q & ~bitmask);
  wire [NPINS-1:0] sel_mask = (channel_select[4:3] == 2'b00) ?
    ({{(NPINS-1){1'b0}}, 1'b1} << channel_select[2:0]) : {NPINS{1'b0}};
  wire [4:0] chan_d = scr_wr ? avs_writedata[4:0] : channel_select;
  wire [NPINS-1:0] sel_next = (chan_d[4:3] == 2'b00) ?
    ({{(NPINS-1){1'b0}}, 1'b1} << chan_d[2:0]) : {NPINS{1'b0}};
  wire [NPINS-1:0] pin_out_d;
  wire [NPINS-1:0] pin_oe_d;
  wire [NPINS-1:0] pin_rd;
  wire complete = (state_q == ST_CONV) & ctick & last_step & ~stop_mode & ~scr_wr;
  wire hold_res = (frozen_q | rh_rd) & (jmode != `ADCC_MODE_TRUNC);
  reg [7:0] new_rh;
  reg [7:0] new_rl;
  reg [31:0] rdata;

  // prescale ratio per divider code
  always @*
  begin
    case (clkcfg_q[`ADCC_CLK_DIV_HI:`ADCC_CLK_DIV_LO])
      3'h0: divmax = 5'h00;
      3'h1: divmax = 5'h01;
      3'h2: divmax = 5'h03;
      3'h3: divmax = 5'h07;
      default: divmax = 5'h0F;
    endcase
  end

  // result formatting
  always @*
  begin
    new_rh = 8'h00;
    new_rl = 8'h00;
    case (jmode)
      `ADCC_MODE_LEFT:
      begin
        new_rh = final_res[9:2];
        new_rl = {final_res[1:0], 6'h00};
      end
      `ADCC_MODE_RIGHT:
      begin
        new_rh = {6'h00, final_res[9:8]};
        new_rl = final_res[7:0];
      end
      `ADCC_MODE_SIGNED:
      begin
        new_rh = {~final_res[9], final_res[8:2]};
        new_rl = {final_res[1:0], 6'h00};
      end
      default:
      begin
        new_rl = final_res[9:2];
      end
    endcase
  end

  always @*
  begin
    rdata = 32'h0000_0000;
    if (avs_address == `ADCC_OFF_SCR)
      rdata[7:0] = {done_q & ~ien_q, ien_q, cont_q, channel_select};
    else if (avs_address == `ADCC_OFF_RH)
      rdata[7:0] = rh_q;
    else if (avs_address == `ADCC_OFF_RL)
      rdata[7:0] = rl_q;
    else if (avs_address == `ADCC_OFF_CLK)
      rdata[7:0] = clkcfg_q;
    else if (avs_address == `ADCC_OFF_PORT_OUT)
      rdata[NPINS-1:0] = pout_q;
    else if (avs_address == `ADCC_OFF_PORT_DIR)
      rdata[NPINS-1:0] = pdir_q;
    else if (avs_address == `ADCC_OFF_PORT_IN)
      rdata[NPINS-1:0] = pin_rd;
  end

  // bus slave: one wait cycle, answer on the second
  always @(posedge mclk)
  begin
    if (reset)
    begin
      ack_q <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= acc;
      avs_waitrequest <= ~acc;
      if (rd)
        avs_readdata <= rdata;
    end
  end

  // registers written by software
  always @(posedge mclk)
  begin
    if (reset)
    begin
      cont_q <= 1'b0;
      ien_q <= 1'b0;
      channel_select <= `ADCC_CH_RESET;
      clkcfg_q <= `ADCC_CLK_RESET;
      pout_q <= {NPINS{1'b0}};
      pdir_q <= {NPINS{1'b0}};
    end
    else if (wr & avs_byteenable[0])
    begin
      if (avs_address == `ADCC_OFF_SCR)
      begin
        ien_q <= avs_writedata[`ADCC_SCR_IEN];
        cont_q <= avs_writedata[`ADCC_SCR_CONT];
        channel_select <= avs_writedata[4:0];
      end
      else if (avs_address == `ADCC_OFF_CLK)
        clkcfg_q <= avs_writedata[7:0];
      else if (avs_address == `ADCC_OFF_PORT_OUT)
        pout_q <= avs_writedata[NPINS-1:0];
      else if (avs_address == `ADCC_OFF_PORT_DIR)
        pdir_q <= avs_writedata[NPINS-1:0];
    end
  end

  // pin takeover, one slice per shared pin
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi = gi + 1)
    begin : g_pin
      assign pin_out_d[gi] = pout_q[gi] & ~sel_next[gi];
      assign pin_oe_d[gi] = pdir_q[gi] & ~sel_next[gi];
      assign pin_rd[gi] = port_pin_in[gi] & ~sel_mask[gi];
    end
  endgenerate

  always @(posedge mclk)
  begin
    if (reset)
    begin
      port_pin_out <= {NPINS{1'b0}};
      port_pin_oe <= {NPINS{1'b0}};
    end
    else
    begin
      port_pin_out <= pin_out_d;
      port_pin_oe <= pin_oe_d;
    end
  end

  // conversion sequencer
  always @(posedge mclk)
  begin
    if (reset)
    begin
      state_q <= ST_IDLE;
      div_q <= 5'h00;
      step_q <= 5'h00;
      sar_q <= {RES_W{1'b0}};
      stopped_q <= 1'b0;
      sample_hold <= 1'b0;
      sar_trial <= {RES_W{1'b0}};
      converter_power_on <= 1'b0;
    end
    else
    begin
      converter_power_on <= ~pwr_off & ~stop_mode;
      if (src_en)
        div_q <= ctick ? 5'h00 : div_q + 5'h01;
      if (stop_mode)
      begin
        state_q <= ST_IDLE;
        sample_hold <= 1'b0;
        if (state_q != ST_IDLE || cont_q)
          stopped_q <= 1'b1;
      end
      else if (scr_wr)
      begin
        state_q <= (avs_writedata[4:0] == `ADCC_CH_OFF) ? ST_IDLE : ST_STAB;
        div_q <= 5'h00;
        step_q <= 5'h00;
        sample_hold <= 1'b0;
      end
      else if (stopped_q)
      begin
        stopped_q <= 1'b0;
        state_q <= pwr_off ? ST_IDLE : ST_STAB;
        div_q <= 5'h00;
      end
      else
      begin
        case (state_q)
          ST_STAB:
            if (ctick)
            begin
              state_q <= ST_CONV;
              step_q <= 5'h00;
              sar_q <= {1'b1, {(RES_W-1){1'b0}}};
              sar_trial <= {1'b1, {(RES_W-1){1'b0}}};
              sample_hold <= 1'b1;
            end
          ST_CONV:
            if (ctick)
            begin
              step_q <= step_q + 5'h01;
              if (step_q == 5'h00)
                sample_hold <= 1'b0;
              if (step_q < 5'h0A)
              begin
                sar_q <= final_res | (bitmask >> 1);
                sar_trial <= final_res | (bitmask >> 1);
              end
              if (last_step)
              begin
                step_q <= 5'h00;
                state_q <= (cont_q & ~pwr_off) ? ST_CONV : ST_IDLE;
                sar_q <= {1'b1, {(RES_W-1){1'b0}}};
                sar_trial <= {1'b1, {(RES_W-1){1'b0}}};
                sample_hold <= cont_q;
              end
            end
          default:
            state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // result registers, done flag and interrupt
  always @(posedge mclk)
  begin
    if (reset)
    begin
      rh_q <= 8'h00;
      rl_q <= 8'h00;
      frozen_q <= 1'b0;
      done_q <= 1'b0;
      conv_irq <= 1'b0;
    end
    else
    begin
      if (rh_rd && jmode != `ADCC_MODE_TRUNC)
        frozen_q <= 1'b1;
      else if (rl_rd || jmode == `ADCC_MODE_TRUNC)
        frozen_q <= 1'b0;
      if (complete && !hold_res)
      begin
        rh_q <= new_rh;
        rl_q <= new_rl;
      end
      if (complete & ~ien_q)
        done_q <= 1'b1;
      else if (rh_rd | rl_rd | ien_q)
        done_q <= 1'b0;
      if (complete & ien_q)
        conv_irq <= 1'b1;
      else if (rh_rd | rl_rd | scr_wr)
        conv_irq <= 1'b0;
    end
  end
endmodule // adcc_control

// ==== rtl/adcc_defines.vh ====
// constants for the converter control block
`ifndef ADCC_DEFINES_VH
`define ADCC_DEFINES_VH
`define ADCC_OFF_SCR 5'h00
`define ADCC_OFF_RH 5'h04
`define ADCC_OFF_RL 5'h08
`define ADCC_OFF_CLK 5'h0C
`define ADCC_OFF_PORT_OUT 5'h10
`define ADCC_OFF_PORT_DIR 5'h14
`define ADCC_OFF_PORT_IN 5'h18
`define ADCC_SCR_DONE 7
`define ADCC_SCR_IEN 6
`define ADCC_SCR_CONT 5
`define ADCC_CLK_SRC 4
`define ADCC_CLK_MODE_HI 3
`define ADCC_CLK_MODE_LO 2
`define ADCC_CLK_DIV_HI 7
`define ADCC_CLK_DIV_LO 5
`define ADCC_CH_RESET 5'h1F
`define ADCC_CH_OFF 5'h1F
`define ADCC_CH_REFH 5'h1D
`define ADCC_CH_REFL 5'h1E
`define ADCC_CLK_RESET 8'h00
`define ADCC_MODE_LEFT 2'h0
`define ADCC_MODE_RIGHT 2'h1
`define ADCC_MODE_SIGNED 2'h2
`define ADCC_MODE_TRUNC 2'h3
`define ADCC_CONV_CYCLES 5'h11
`define ADCC_FULL_SCALE 10'h3FF
`define ADCC_ZERO_SCALE 10'h000
`endif

// ==== verification/adcc_sva.sv ====
// checker for the converter control block
`timescale 1ns/1ps
module adcc_sva #(parameter NPINS = 8) (
  input wire mclk,
  input wire reset,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire sample_hold,
  input wire stop_mode,
  input wire [NPINS-1:0] port_pin_oe,
  input wire [4:0] channel_select,
  input wire converter_power_on,
  input wire conv_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire ack = !avs_waitrequest;
  wire scr_wr = avs_write && ack && avs_address == 5'h00;
  wire res_rd = avs_read && ack && (avs_address == 5'h04 || avs_address == 5'h08);
  property p_ans; (avs_read || avs_write) |-> ##[0:1] ack; endproperty
  a_ans: assert property (p_ans) else $error("request not answered");
  property p_one; ack |=> !ack; endproperty
  a_one: assert property (p_one) else $error("answer longer than one cycle");
  property p_pin; channel_select < 5'h08 |-> !port_pin_oe[channel_select]; endproperty
  a_pin: assert property (p_pin) else $error("selected pin driven");
  property p_rdz;
    avs_read && ack && avs_address == 5'h18 && channel_select < 5'h08
      |-> !avs_readdata[channel_select];
  endproperty
  a_rdz: assert property (p_rdz) else $error("selected pin reads one");
  property p_off;
    (channel_select == 5'h1F && $stable(channel_select)) || (stop_mode && $past(stop_mode))
      |-> !converter_power_on;
  endproperty
  a_off: assert property (p_off) else $error("converter powered");
  property p_len;
    @(posedge mclk) disable iff (reset || stop_mode)
    scr_wr && avs_writedata[6] && avs_writedata[4:0] < 5'h08
      |=> !conv_irq [*8] ##[7:13] conv_irq;
  endproperty
  a_len: assert property (p_len) else $error("conversion length wrong");
  property p_hold; conv_irq && !avs_read && !avs_write |=> conv_irq; endproperty
  a_hold: assert property (p_hold) else $error("interrupt dropped");
  property p_clr; scr_wr || res_rd |=> !conv_irq; endproperty
  a_clr: assert property (p_clr) else $error("interrupt not cleared");
  property p_nodone;
    avs_read && ack && avs_address == 5'h00 && avs_readdata[6] |-> !avs_readdata[7];
  endproperty
  a_nodone: assert property (p_nodone) else $error("done with interrupt on");
  property p_stop; stop_mode && $past(stop_mode) |-> !$rose(conv_irq); endproperty
  a_stop: assert property (p_stop) else $error("conversion in stop");
  property p_samp; sample_hold |-> converter_power_on && !$past(stop_mode); endproperty
  a_samp: assert property (p_samp) else $error("sampling while powered down");
  c_samp: cover property ($rose(sample_hold));
  c_irq: cover property ($rose(conv_irq));
  c_stop: cover property (stop_mode && $past(stop_mode));
  c_pin: cover property (avs_read && ack && avs_address == 5'h18);
endmodule // adcc_sva
bind adcc_control adcc_sva #(.NPINS(NPINS)) i_adcc_sva (.mclk, .reset, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .sample_hold,
  .stop_mode,
  .port_pin_oe, .channel_select, .converter_power_on, .conv_irq);

// ==== verification/adcc_cmp_model.sv ====
// comparator model standing in for the analog core
`timescale 1ns/1ps
module adcc_cmp_model (
  input wire [9:0] level,
  input wire [4:0] channel_select,
  input wire [9:0] sar_trial,
  output wire sar_compare_hi
);
  wire [9:0] vin = channel_select == 5'h1D ? 10'h3FF :
    channel_select == 5'h1E ? 10'h000 : level + {5'h00, channel_select};
  assign sar_compare_hi = vin >= sar_trial;
endmodule // adcc_cmp_model

// ==== verification/tb_top.sv ====
// self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_top;
  logic mclk = 0, reset = 1, avs_read = 0, avs_write = 0, stop_mode = 0;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, lfsr = 32'hE75250DC;
  logic [7:0] ext = 8'h00;
  logic [9:0] lvl = 10'h000;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, sar_compare_hi, converter_power_on, conv_irq;
  wire [7:0] port_pin_out, port_pin_oe;
  wire [4:0] channel_select;
  wire [9:0] sar_trial;
  wire [7:0] pins = (port_pin_oe & port_pin_out) | (~port_pin_oe & ext);
  int fail_count = 0, cmp_count = 0;
  logic [31:0] expq[$];
  initial forever #2.5 mclk = ~mclk;
  adcc_control i_adcc_control (.mclk, .reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
    .osc_clk_en(1'b1), .stop_mode, .port_pin_in(pins), .port_pin_out, .port_pin_oe,
    .channel_select, .sample_hold(), .sar_trial, .sar_compare_hi, .converter_power_on,
    .conv_irq);
  adcc_cmp_model i_adcc_cmp_model (.level(lvl), .channel_select, .sar_trial,
    .sar_compare_hi);
  function automatic [31:0] rnd(input [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic [9:0] res(input [4:0] c);
    return c == 5'h1D ? 10'h3FF : c == 5'h1E ? 10'h000 : lvl + {5'h00, c};
  endfunction
  function automatic [15:0] fmt(input [1:0] m, input [9:0] r);
    case (m)
      2'h0: return {r[9:2], r[1:0], 6'h00};
      2'h1: return {6'h00, r};
      2'h2: return {~r[9], r[8:2], r[1:0], 6'h00};
      default: return {8'h00, r[9:2]};
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  always @(posedge mclk)
    if (avs_read && avs_waitrequest === 1'b0)
      chk(avs_readdata, expq.pop_front());
  task automatic bus(input logic w, input [4:0] a, input [7:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !w;
    avs_write <= w;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input [4:0] a, input [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input [4:0] a, input [7:0] e);
    expq.push_back({24'h0, e});
    bus(1'b0, a, 8'h00);
  endtask
  task automatic conv(input [1:0] m, input [7:0] scr);
    logic [15:0] f;
    int i;
    wr(5'h0C, {3'h0, 1'b1, m, 2'h0});
    wr(5'h00, scr);
    if (scr[6])
      for (i = 0; i < 60 && conv_irq !== 1'b1; i++) @(posedge mclk);
    else
      repeat (40) @(posedge mclk);
    if (scr[6]) chk(conv_irq, 32'h1);
    rd(5'h00, scr[6] ? scr : scr | 8'h80);
    f = fmt(m, res(scr[4:0]));
    rd(5'h04, f[15:8]);
    rd(5'h08, f[7:0]);
  endtask
  task results;
    $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    logic [15:0] f;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    rd(5'h00, 8'h1F);
    rd(5'h0C, 8'h00);
    rd(5'h1C, 8'h00);
    lfsr = rnd(lfsr);
    lvl <= lfsr[9:0];
    ext <= lfsr[7:0];
    for (int m = 0; m < 4; m++) conv(2'(m), 8'(8'h41 + 2 * m));
    wr(5'h14, 8'hFF);
    wr(5'h10, lfsr[15:8]);
    @(posedge mclk);
    chk(port_pin_oe, 32'h7F);
    chk(port_pin_out & 8'h7F, lfsr[15:8] & 8'h7F);
    rd(5'h18, lfsr[15:8] & 8'h7F);
    wr(5'h14, 8'h00);
    rd(5'h18, ext & 8'h7F);
    conv(2'h1, 8'h5D);
    conv(2'h1, 8'h5E);
    conv(2'h1, 8'h04);
    rd(5'h00, 8'h04);
    repeat (60) @(posedge mclk);
    rd(5'h00, 8'h04);
    wr(5'h00, 8'h00);
    repeat (5) @(posedge mclk);
    conv(2'h1, 8'h46);
    wr(5'h0C, 8'h10);
    wr(5'h00, 8'h20);
    repeat (40) @(posedge mclk);
    f = fmt(2'h0, res(5'h00));
    rd(5'h04, f[15:8]);
    lfsr = rnd(lfsr);
    lvl <= lfsr[9:0];
    repeat (45) @(posedge mclk);
    rd(5'h08, f[7:0]);
    repeat (45) @(posedge mclk);
    f = fmt(2'h0, res(5'h00));
    rd(5'h04, f[15:8]);
    rd(5'h08, f[7:0]);
    wr(5'h00, 8'h1F);
    repeat (2) @(posedge mclk);
    chk(converter_power_on, 32'h0);
    wr(5'h00, 8'h42);
    repeat (5) @(posedge mclk);
    stop_mode <= 1'b1;
    repeat (40) @(posedge mclk);
    chk(conv_irq, 32'h0);
    stop_mode <= 1'b0;
    conv(2'h1, 8'h42);
    results();
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    results();
  end
endmodule // tb_top
